// File: rtl/aism_pkg.sv
// Package: register map, field positions and reset values of the ID/status/mode bank
package aism_pkg;
    // Register indices; byte address is four times the index
    localparam logic [1:0] IDX_ID = 2'h0;
    localparam logic [1:0] IDX_STATUS = 2'h1;
    localparam logic [1:0] IDX_MODE = 2'h2;
    localparam int AXI_ADDR_W = 4;
    // Status field positions
    localparam int ST_LOCK = 15;
    localparam int ST_RESYNC = 14;
    localparam int ST_REGMAP = 13;
    localparam int ST_CRC_ERR = 12;
    localparam int ST_CRC_TYPE = 11;
    localparam int ST_RESET = 10;
    localparam int ST_WLEN_LO = 8;
    localparam int ST_CH1 = 1;
    localparam int ST_CH0 = 0;
    // Mode field positions
    localparam int MD_REGCRC = 13;
    localparam int MD_RXCRC = 12;
    localparam int MD_CRC_TYPE = 11;
    localparam int MD_RESET = 10;
    localparam int MD_WLEN_LO = 8;
    localparam int MD_TIMEOUT = 4;
    localparam int MD_SRC_LO = 2;
    localparam int MD_IDLE = 1;
    localparam int MD_FMT = 0;
    // Identification field positions
    localparam int ID_CNT_LO = 8;
    localparam int ID_TOP_LO = 12;
    // Reset values
    localparam logic [15:0] STATUS_RST = 16'h0500;
    localparam logic [15:0] MODE_RST = 16'h0510;
    localparam logic [3:0] CHAN_CNT_DEF = 4'h2;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Read channel state machine
    typedef enum logic [1:0] {
        AISM_RD_IDLE = 2'b01,
        AISM_RD_RESP = 2'b10
    } aism_rd_state_t;
endpackage

// File: rtl/aism_sticky_flag.sv
// Module: one sticky event flag, set wins over clear
`timescale 1ns/10ps
`default_nettype none
module aism_sticky_flag #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic set,
    input wire logic clr,
    output logic flag
);
    logic next_flag;

    // A set in the clearing cycle survives, so no event is lost
    always_comb begin
        next_flag = set | (flag & ~clr);
    end

    // Register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag <= RST_VAL;
        end else begin
            flag <= next_flag;
        end
    end
endmodule // aism_sticky_flag
`default_nettype wire

// File: rtl/aism_regs.sv
// Module: identification, status and mode register bank behind AXI4-Lite
`timescale 1ns/10ps
`default_nettype none
module aism_regs
    import aism_pkg::*;
#(
    parameter logic [3:0] CHANNEL_COUNT = CHAN_CNT_DEF,
    parameter logic [3:0] ID_TOP = 4'h0, // Arbitrary value
    parameter logic [7:0] ID_REVISION = 8'h5A // Arbitrary value
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic interface_locked,
    input wire logic resync_event,
    input wire logic regmap_crc_change,
    input wire logic input_crc_error,
    input wire logic ch1_new_data_flag,
    input wire logic ch0_new_data_flag,
    output logic regmap_crc_en,
    output logic input_crc_en,
    output logic crc_type_ansi,
    output logic [1:0] word_length_select,
    output logic timeout_en,
    output logic [1:0] ready_pin_source_select,
    output logic ready_pin_idle_state,
    output logic ready_pin_pulse_format
);
    // ********************************************************
    // Write channel
    // ********************************************************
    logic aw_full, next_aw_full, w_full, next_w_full;
    logic [1:0] aw_idx, next_aw_idx;
    logic aw_bad, next_aw_bad;
    logic [15:0] wd, next_wd;
    logic [1:0] wstb, next_wstb;
    logic next_awready, next_wready, next_bvalid;
    logic [1:0] next_bresp;
    logic wr_fire;

    // Address and data are latched independently, then committed together
    always_comb begin
        next_aw_full = aw_full;
        next_aw_idx = aw_idx;
        next_aw_bad = aw_bad;
        next_w_full = w_full;
        next_wd = wd;
        next_wstb = wstb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        wr_fire = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_aw_idx = s_axi_awaddr[3:2];
            next_aw_bad = (s_axi_awaddr[3:2] > IDX_MODE);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
            next_wd = s_axi_wdata[15:0];
            next_wstb = s_axi_wstrb[1:0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_full && w_full && !s_axi_bvalid) begin
            wr_fire = 1'b1;
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = aw_bad ? RESP_SLVERR : RESP_OKAY;
        end
        // Ready only while the holding slot is free and no response pending
        next_awready = !next_aw_full && !next_bvalid;
        next_wready = !next_w_full && !next_bvalid;
    end

    // Register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {aw_full, w_full, aw_bad} <= 3'h0;
            aw_idx <= 2'h0;
            {wd, wstb} <= 18'h0;
            {s_axi_awready, s_axi_wready} <= 2'h0;
            {s_axi_bvalid, s_axi_bresp} <= {1'b0, RESP_OKAY};
        end else begin
            {aw_full, w_full, aw_bad} <= {next_aw_full, next_w_full, next_aw_bad};
            aw_idx <= next_aw_idx;
            {wd, wstb} <= {next_wd, next_wstb};
            {s_axi_awready, s_axi_wready} <= {next_awready, next_wready};
            {s_axi_bvalid, s_axi_bresp} <= {next_bvalid, next_bresp};
        end
    end

    // ********************************************************
    // Mode register
    // ********************************************************
    logic mode_wr, clr_reset_flag;
    logic [15:0] mode, next_mode;

    // Only the mode index is writable; other indices ignore the data
    assign mode_wr = wr_fire && (aw_idx == IDX_MODE);
    assign clr_reset_flag = mode_wr && wstb[1] && !wd[MD_RESET];

    // Reserved bits are not stored, so they read zero whatever is written
    always_comb begin
        next_mode = mode;
        if (mode_wr && wstb[1]) begin
            next_mode[MD_CRC_TYPE+:3] = wd[MD_CRC_TYPE+:3];
            next_mode[MD_WLEN_LO+:2] = wd[MD_WLEN_LO+:2];
        end
        // Bits 4:0 are all controls, so the low lane is copied as one field
        if (mode_wr && wstb[0]) begin
            next_mode[MD_FMT+:5] = wd[MD_FMT+:5];
        end
    end

    // Register; outputs are copies of the stored fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= MODE_RST;
            {regmap_crc_en, input_crc_en, crc_type_ansi} <= MODE_RST[MD_CRC_TYPE+:3];
            word_length_select <= MODE_RST[MD_WLEN_LO+:2];
            timeout_en <= MODE_RST[MD_TIMEOUT];
            ready_pin_source_select <= MODE_RST[MD_SRC_LO+:2];
            {ready_pin_idle_state, ready_pin_pulse_format} <= MODE_RST[MD_FMT+:2];
        end else begin
            mode <= next_mode;
            {regmap_crc_en, input_crc_en, crc_type_ansi} <= next_mode[MD_CRC_TYPE+:3];
            word_length_select <= next_mode[MD_WLEN_LO+:2];
            timeout_en <= next_mode[MD_TIMEOUT];
            ready_pin_source_select <= next_mode[MD_SRC_LO+:2];
            {ready_pin_idle_state, ready_pin_pulse_format} <= next_mode[MD_FMT+:2];
        end
    end

    // ********************************************************
    // Status flags
    // ********************************************************
    logic st_rd, resync_occurred_flag, f_regmap, f_crc_err, f_reset;
    logic lock_q, ch1_q, ch0_q;
    logic [15:0] status, id_word;

    // Event flags clear when software reads the status word
    assign st_rd = s_axi_arvalid && s_axi_arready && (s_axi_araddr[3:2] == IDX_STATUS);

    aism_sticky_flag #(.RST_VAL(STATUS_RST[ST_RESYNC])) u_resync (
        .aclk(aclk), .aresetn(aresetn), .clr(st_rd),
        .set(resync_event), .flag(resync_occurred_flag)
    );
    // Change reports only count while register-map CRC runs
    aism_sticky_flag #(.RST_VAL(STATUS_RST[ST_REGMAP])) u_regmap (
        .aclk(aclk), .aresetn(aresetn), .clr(st_rd),
        .set(regmap_crc_change && regmap_crc_en), .flag(f_regmap)
    );
    aism_sticky_flag #(.RST_VAL(STATUS_RST[ST_CRC_ERR])) u_crc_err (
        .aclk(aclk), .aresetn(aresetn), .clr(st_rd),
        .set(input_crc_error && input_crc_en), .flag(f_crc_err)
    );
    // Set only by reset itself; cleared through the mode register
    aism_sticky_flag #(.RST_VAL(STATUS_RST[ST_RESET])) u_reset (
        .aclk(aclk), .aresetn(aresetn), .set(1'b0),
        .clr(clr_reset_flag), .flag(f_reset)
    );

    // Level inputs sampled once so the read word is stable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_q <= STATUS_RST[ST_LOCK];
            ch1_q <= STATUS_RST[ST_CH1];
            ch0_q <= STATUS_RST[ST_CH0];
        end else begin
            lock_q <= interface_locked;
            ch1_q <= ch1_new_data_flag;
            ch0_q <= ch0_new_data_flag;
        end
    end

    // Assemble read words
    always_comb begin
        status = 16'h0000;
        status[ST_LOCK] = lock_q;
        status[ST_RESYNC] = resync_occurred_flag;
        status[ST_REGMAP] = f_regmap;
        status[ST_CRC_ERR] = f_crc_err;
        status[ST_CRC_TYPE] = mode[MD_CRC_TYPE];
        status[ST_RESET] = f_reset;
        status[ST_WLEN_LO+:2] = mode[MD_WLEN_LO+:2];
        status[ST_CH1] = ch1_q;
        status[ST_CH0] = ch0_q;
        id_word = {ID_TOP, CHANNEL_COUNT, ID_REVISION};
    end

    // ********************************************************
    // Read channel
    // ********************************************************
    aism_rd_state_t rd_state, next_rd_state;
    logic next_arready, next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // One read at a time; the word is captured at address acceptance
    always_comb begin
        next_rd_state = rd_state;
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        case (rd_state)
            AISM_RD_IDLE: begin
                next_arready = 1'b1;
                if (s_axi_arvalid && s_axi_arready) begin
                    next_rd_state = AISM_RD_RESP;
                    next_arready = 1'b0;
                    next_rvalid = 1'b1;
                    next_rresp = RESP_OKAY;
                    case (s_axi_araddr[3:2])
                        IDX_ID: next_rdata = {16'h0000, id_word};
                        IDX_STATUS: next_rdata = {16'h0000, status};
                        IDX_MODE: next_rdata = {16'h0000, mode[15:11], f_reset,
                            mode[9:0]};
                        default: begin
                            next_rdata = 32'h00000000;
                            next_rresp = RESP_SLVERR;
                        end
                    endcase
                end
            end
            AISM_RD_RESP: begin
                if (s_axi_rready) begin
                    next_rd_state = AISM_RD_IDLE;
                    next_rvalid = 1'b0;
                    next_arready = 1'b1;
                end
            end
            default: begin
                next_rd_state = AISM_RD_IDLE;
                next_rvalid = 1'b0;
                next_arready = 1'b0;
            end
        endcase
    end

    // Register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= AISM_RD_IDLE;
            {s_axi_arready, s_axi_rvalid} <= 2'h0;
            {s_axi_rresp, s_axi_rdata} <= {RESP_OKAY, 32'h00000000};
        end else begin
            rd_state <= next_rd_state;
            {s_axi_arready, s_axi_rvalid} <= {next_arready, next_rvalid};
            {s_axi_rresp, s_axi_rdata} <= {next_rresp, next_rdata};
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_status_read;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == IDX_STATUS;
    endsequence

    chk_lock_mirror: assert property ($past(interface_locked) == status[ST_LOCK])
        else $error("lock bit does not follow lock input");
    chk_resync_sets: assert property (resync_event |=> status[ST_RESYNC])
        else $error("resync event not recorded");
    chk_regmap_sets: assert property (regmap_crc_change && regmap_crc_en |=> f_regmap)
        else $error("register map change not recorded");
    chk_crc_err_gated: assert property (!input_crc_en && !f_crc_err |=> !f_crc_err)
        else $error("crc error set while checking disabled");
    chk_status_mirror: assert property (status[ST_CRC_TYPE] == crc_type_ansi
        && status[ST_WLEN_LO+:2] == word_length_select)
        else $error("status does not mirror mode fields");
    chk_reset_clear: assert property (clr_reset_flag && !$past(aresetn) == 1'b0
        |=> !status[ST_RESET])
        else $error("reset flag not cleared by mode write");
    chk_reserved_zero: assert property (status[7:2] == 6'h00)
        else $error("reserved status bits not zero");
    chk_status_rdata: assert property (s_status_read |=> s_axi_rvalid
        && s_axi_rdata[15:0] == $past(status) && s_axi_rdata[31:16] == 16'h0000)
        else $error("status read returned wrong word");
    chk_id_count: assert property (rd_state == AISM_RD_IDLE && s_axi_arvalid && s_axi_arready
        && s_axi_araddr[3:2] == IDX_ID |=> s_axi_rdata[11:8] == CHANNEL_COUNT)
        else $error("channel count field wrong");
    chk_ro_write_ignored: assert property (wr_fire && aw_idx != IDX_MODE |=> $stable(mode))
        else $error("write to read-only index changed mode");
    chk_mode_write: assert property (mode_wr && wstb == 2'h3 |=> regmap_crc_en
        == $past(wd[MD_REGCRC]) && timeout_en == $past(wd[MD_TIMEOUT])
        && ready_pin_source_select == $past(wd[MD_SRC_LO+:2]))
        else $error("mode fields not written");
endmodule // aism_regs
`default_nettype wire

// File: test/aism_host_model.sv
// AXI4-Lite host model that issues register reads and writes to the bank
`timescale 1ns/10ps
`default_nettype none
module aism_host_model
    import aism_pkg::*;
(
    input wire logic aclk,
    output logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [AXI_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // ****************
    // Bus cycles
    // ****************
    // Idle at time zero; nothing is offered until the bench asks
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h000;
        s_axi_wdata = 32'h00000000;
    end

    // Address and data go out together; each is dropped on its own ready
    task automatic write_reg(input logic [3:0] a, input logic [15:0] d, input logic [3:0] s);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'($urandom), d}; // Upper lanes carry noise, the bank ignores them
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awready && !aw_done) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a; // Released lines must not show a stale address
            end
            if (s_axi_wready && !w_done) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~s_axi_wdata;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    // Read request held until taken, rready held until the answer
    task automatic read_reg(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
endmodule // aism_host_model
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the identification, status and mode register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import aism_pkg::*;
;
    localparam logic [3:0] CNT_V = 4'h2;
    localparam logic [3:0] TOP_V = 4'h0; // Arbitrary value
    localparam logic [7:0] REV_V = 8'hC3; // Arbitrary value
    localparam logic [AXI_ADDR_W-1:0] A_ID = {IDX_ID, 2'b00};
    localparam logic [AXI_ADDR_W-1:0] A_ST = {IDX_STATUS, 2'b00};
    localparam logic [AXI_ADDR_W-1:0] A_MD = {IDX_MODE, 2'b00};
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [3:0] s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, word_length_select, ready_pin_source_select;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic interface_locked, resync_event, regmap_crc_change, input_crc_error;
    logic ch1_new_data_flag, ch0_new_data_flag, regmap_crc_en, input_crc_en, crc_type_ansi;
    logic timeout_en, ready_pin_idle_state, ready_pin_pulse_format, lk;
    logic [15:0] mv;
    logic [2:0] fl;
    logic [1:0] ch;
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];
    int errors = 0;
    int samples_checked = 0;

    aism_regs #(.CHANNEL_COUNT(CNT_V), .ID_TOP(TOP_V), .ID_REVISION(REV_V)) dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .interface_locked, .resync_event,
        .regmap_crc_change, .input_crc_error, .ch1_new_data_flag, .ch0_new_data_flag,
        .regmap_crc_en, .input_crc_en, .crc_type_ansi, .word_length_select, .timeout_en,
        .ready_pin_source_select, .ready_pin_idle_state, .ready_pin_pulse_format
    );
    aism_host_model host (
        .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready
    );

    // ****************
    // Checking
    // ****************
    // Expected status from the tracked inputs, flags and mode image
    function automatic logic [15:0] st();
        return {lk, fl, mv[11:8], 6'h00, ch};
    endfunction

    task automatic note(input logic [33:0] got, input logic [33:0] want);
        samples_checked++;
        if (got !== want) begin
            errors++;
            $display("unexpected value at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic cmp_b(input logic [1:0] got);
        logic [1:0] e;
        e = (exp_b.size() > 0) ? exp_b.pop_front() : 2'bxx;
        note({32'h0, got}, {32'h0, e});
    endtask

    task automatic cmp_r(input logic [33:0] got);
        logic [33:0] e;
        e = (exp_r.size() > 0) ? exp_r.pop_front() : 34'bx;
        note(got, e);
    endtask

    // Mode outputs against the image; bit 10 is a flag, not a stored control
    task automatic cmp_mode();
        note({20'h0, regmap_crc_en, input_crc_en, crc_type_ansi, 1'b0, word_length_select,
            3'h0, timeout_en, ready_pin_source_select, ready_pin_idle_state,
            ready_pin_pulse_format}, {18'h0, mv & 16'h3B1F});
    endtask

    // Watcher: each bus answer takes the oldest note off its queue
    always @(posedge aclk) begin
        if ((s_axi_bvalid & s_axi_bready) === 1'b1) begin
            cmp_b(s_axi_bresp);
        end
        if ((s_axi_rvalid & s_axi_rready) === 1'b1) begin
            cmp_r({s_axi_rresp, s_axi_rdata});
        end
    end

    // ****************
    // Stimulus
    // ****************
    task automatic rd(input logic [3:0] a, input logic [15:0] d, input logic [1:0] r);
        exp_r.push_back({r, 16'h0000, d});
        host.read_reg(a);
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [3:0] s,
        input logic [1:0] r);
        exp_b.push_back(r);
        host.write_reg(a, d, s);
    endtask

    // One-cycle event pulses: resync, map change, input error
    task automatic fire(input logic [2:0] f);
        @(posedge aclk);
        {resync_event, regmap_crc_change, input_crc_error} <= f;
        @(posedge aclk);
        {resync_event, regmap_crc_change, input_crc_error} <= 3'h0;
    endtask

    task automatic set_in(input logic l, input logic [1:0] c);
        @(posedge aclk);
        interface_locked <= l;
        {ch1_new_data_flag, ch0_new_data_flag} <= c;
        lk = l;
        ch = c;
    endtask

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Free-running 40 MHz clock
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        errors++;
        $display("unexpected timeout at %0t: sequence hung", $time);
        close_out();
    end

    // Main sequence
    initial begin
        void'($urandom(32'hFBF60338));
        aresetn = 1'b0;
        {interface_locked, resync_event, regmap_crc_change, input_crc_error} = 4'h0;
        {ch1_new_data_flag, ch0_new_data_flag} = 2'h0;
        {lk, fl, ch, mv} = {6'h00, 16'h0510};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_ID, {TOP_V, CNT_V, REV_V}, RESP_OKAY);
        rd(A_ST, 16'h0500, RESP_OKAY);
        rd(A_MD, 16'h0510, RESP_OKAY);
        cmp_mode();
        wr(A_ID, 16'hFFFF, 4'hF, RESP_OKAY);
        wr(A_ST, 16'hFFFF, 4'hF, RESP_OKAY);
        rd(A_ID, {TOP_V, CNT_V, REV_V}, RESP_OKAY);
        rd(A_ST, 16'h0500, RESP_OKAY);
        rd(4'hC, 16'h0000, RESP_SLVERR);
        wr(4'hC, 16'h1234, 4'hF, RESP_SLVERR);
        // Every length and polynomial code, other controls random
        for (int i = 0; i < 8; i++) begin
            mv = 16'($urandom) & 16'h3B1F;
            mv[10] = 1'b1;
            mv[9:8] = i[1:0];
            mv[11] = i[2];
            wr(A_MD, mv, 4'h3, RESP_OKAY);
            cmp_mode();
            rd(A_MD, mv, RESP_OKAY);
            rd(A_ST, st(), RESP_OKAY);
        end
        // Input check on, map check off: resync and, of the two CRC flags, only the enabled one may set
        mv = 16'h1510;
        wr(A_MD, mv, 4'h3, RESP_OKAY);
        set_in(1'b1, 2'b10);
        fire(3'b111);
        fl = 3'b101;
        rd(A_ST, st(), RESP_OKAY);
        fl = 3'b000;
        rd(A_ST, st(), RESP_OKAY);
        mv = 16'h2510;
        wr(A_MD, mv, 4'h3, RESP_OKAY);
        fire(3'b111);
        fl = 3'b110;
        set_in(1'b0, 2'b01);
        rd(A_ST, st(), RESP_OKAY);
        fl = 3'b000;
        // Clearing the reset flag, then a low-byte-only write
        mv = 16'h2110;
        wr(A_MD, mv, 4'h2, RESP_OKAY);
        rd(A_ST, st(), RESP_OKAY);
        wr(A_MD, 16'h3B0E, 4'h1, RESP_OKAY);
        mv[7:0] = 8'h0E;
        cmp_mode();
        rd(A_MD, mv, RESP_OKAY);
        // A second reset restores every default and the reset flag
        set_in(1'b0, 2'b00);
        do_reset();
        mv = 16'h0510;
        rd(A_ST, 16'h0500, RESP_OKAY);
        cmp_mode();
        rd(A_MD, 16'h0510, RESP_OKAY);
        repeat (2) @(posedge aclk);
        close_out();
    end
endmodule // tb_top
`default_nettype wire
